// ===== mode_reg_access.v
// mode register write/read path of a low power ddr3 controller
//
// Contract
// - any of 256 mode registers reachable by an 8-bit register number.
// - register number and opcode travel only on the command/address bus.
// - low 8 address bits, lsb at bit 0, select mode register N.
// - after user MRW, internal latency and burst settings follow the new value.
// - init programs mode registers with build-time values, kept until MRW.
// - MR1 BL 3'b011, WR 3'b100; MR2 latency 4'b0100, other bits zero.
// - MR3 drive strength 4'b0010; MR11 termination 2'b00, power-down bit zero.
// - each MRR gives read-valid for exactly two system clocks.
// - first read-valid cycle carries register contents on read_data[7:0].
// - write request to data delay selectable 1, 2 or 3, default 1.
// - refresh burst count one of 1..8192 set, default 32.
// - read latency 3, 6 or 8, default 6; write latency follows.
// - memory data width 16 or 32, default 32.
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mra_map.vh"
module mode_reg_access #(
    parameter DATA_WIDTH = 32,
    parameter ADDR_WIDTH = 28,
    parameter READ_LATENCY = 6,
    parameter WR_DATA_DELAY = 1,
    parameter REF_BURST_SEL = 2
) (
    // clock and reset
    input wire mclk_in,
    input wire sys_rst_in,
    // user command port
    input wire cmd_valid_in,
    input wire [3:0] cmd_in,
    input wire [ADDR_WIDTH-1:0] addr_in,
    output reg cmd_rdy_out,
    output reg init_done_out,
    // user read data
    output reg read_data_valid_out,
    output reg [4*DATA_WIDTH-1:0] read_data_out,
    // configuration seen by the rest of the controller
    output reg [1:0] write_request_to_data_delay_out,
    output reg [13:0] refresh_burst_count_out,
    output reg [3:0] read_latency_out,
    output reg [3:0] write_latency_out,
    output reg [2:0] burst_length_code_out,
    // memory side
    input wire mem_clk_in,
    input wire [DATA_WIDTH-1:0] mem_dq_in,
    output reg [9:0] memory_cmd_addr_bus_out,
    output reg mem_cs_n_out,
    // avalon-mm register slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out
);

// ----------------------------------------
// states and build-time constants
// ----------------------------------------
localparam [5:0] S_INIT = 6'h01;
localparam [5:0] S_IDLE = 6'h02;
localparam [5:0] S_HI = 6'h04;
localparam [5:0] S_LO = 6'h08;
localparam [5:0] S_WAIT = 6'h10;
localparam [5:0] S_RESP = 6'h20;

localparam [3:0] INIT_RLWL = (READ_LATENCY == 3) ? `RLWL_RL3 :
    (READ_LATENCY == 8) ? `RLWL_RL8 : `RLWL_RL6;
localparam [1:0] WDLY_INIT = (WR_DATA_DELAY == 2) ? 2'h2 :
    (WR_DATA_DELAY == 3) ? 2'h3 : `WDLY_RST;
localparam [2:0] RSEL_INIT = REF_BURST_SEL[2:0];

// ----------------------------------------
// declarations
// ----------------------------------------
reg [5:0] state_r;
reg [1:0] init_idx_r;
reg is_mrr_r;
reg from_init_r;
reg [7:0] ma_r;
reg [7:0] op_r;
reg [4:0] cnt_r;
reg [7:0] rbyte_r;
reg link_d_r;
reg [2:0] bl_r;
reg [2:0] wr_r;
reg [3:0] rlwl_r;
reg nwre_r;
reg wlsel_r;
reg wlev_r;
reg [3:0] ds_r;
reg [1:0] odt_r;
reg pd_r;
reg cmd_en_r;
reg [1:0] wdly_r;
reg [2:0] rsel_r;
wire link_s;
wire [7:0] dq_s;
wire link_rise;
wire link_fall;
wire [3:0] rl_now;
wire [4:0] wait_tgt;
wire accept;
wire bus_req;
wire cmd_mr;

// ----------------------------------------
// link clock and memory data crossing
// ----------------------------------------
sync2 #(.WIDTH(9)) u_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({mem_clk_in, mem_dq_in[7:0]}),
    .sync_out({link_s, dq_s})
);

always @(posedge mclk_in) begin
    if (sys_rst_in) begin
        link_d_r <= 1'b0;
    end else begin
        link_d_r <= link_s;
    end
end

assign link_rise = link_s & ~link_d_r;
assign link_fall = ~link_s & link_d_r;

// ----------------------------------------
// helpers
// ----------------------------------------
function [7:0] init_ma;
    input [1:0] idx;
    begin
        case (idx)
            2'h0: init_ma = `MR_BURST;
            2'h1: init_ma = `MR_LAT;
            2'h2: init_ma = `MR_DRIVE;
            default: init_ma = `MR_TERM;
        endcase
    end
endfunction

function [7:0] init_op;
    input [1:0] idx;
    begin
        case (idx)
            2'h0: init_op = {`INIT_WR, 2'h0, `INIT_BL};
            2'h1: init_op = {4'h0, INIT_RLWL};
            2'h2: init_op = {4'h0, `INIT_DS};
            default: init_op = {5'h00, 1'b0, `INIT_ODT};
        endcase
    end
endfunction

function [13:0] burst_count;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: burst_count = 14'h0001;
            3'h1: burst_count = 14'h0008;
            3'h2: burst_count = 14'h0020;
            3'h3: burst_count = 14'h0200;
            3'h4: burst_count = 14'h0400;
            3'h5: burst_count = 14'h0800;
            3'h6: burst_count = 14'h1000;
            default: burst_count = 14'h2000;
        endcase
    end
endfunction

// unknown latency codes fall back to rl 6
assign rl_now = (rlwl_r == `RLWL_RL3) ? 4'h3 :
    (rlwl_r == `RLWL_RL8) ? 4'h8 : 4'h6;
assign wait_tgt = is_mrr_r ? ({1'b0, rl_now} + `T_MRR) : `T_MRW;
assign cmd_mr = (cmd_in == `CMD_MRW) || (cmd_in == `CMD_MRR);
assign accept = cmd_valid_in && cmd_rdy_out && cmd_mr;

// ----------------------------------------
// command sequencer
// ----------------------------------------
always @(posedge mclk_in) begin
    if (sys_rst_in) begin
        state_r <= S_INIT;
        init_idx_r <= 2'h0;
        init_done_out <= 1'b0;
        is_mrr_r <= 1'b0;
        from_init_r <= 1'b0;
        ma_r <= 8'h00;
        op_r <= 8'h00;
        cnt_r <= 5'h00;
        rbyte_r <= 8'h00;
        cmd_rdy_out <= 1'b0;
        read_data_valid_out <= 1'b0;
        read_data_out <= {4*DATA_WIDTH{1'b0}};
        memory_cmd_addr_bus_out <= 10'h000;
        mem_cs_n_out <= 1'b1;
        bl_r <= 3'h0;
        wr_r <= 3'h0;
        rlwl_r <= INIT_RLWL;
        nwre_r <= 1'b0;
        wlsel_r <= 1'b0;
        wlev_r <= 1'b0;
        ds_r <= 4'h0;
        odt_r <= 2'h0;
        pd_r <= 1'b0;
    end else begin
        case (state_r)
            S_INIT: begin
                // init rides the same issue path as user writes
                ma_r <= init_ma(init_idx_r);
                op_r <= init_op(init_idx_r);
                is_mrr_r <= 1'b0;
                from_init_r <= 1'b1;
                state_r <= S_HI;
            end
            S_IDLE: begin
                if (accept) begin
                    cmd_rdy_out <= 1'b0;
                    ma_r <= addr_in[7:0];
                    op_r <= (cmd_in == `CMD_MRW) ? addr_in[15:8] : 8'h00;
                    is_mrr_r <= (cmd_in == `CMD_MRR);
                    from_init_r <= 1'b0;
                    state_r <= S_HI;
                end else begin
                    cmd_rdy_out <= cmd_en_r;
                end
            end
            S_HI: begin
                if (link_rise) begin
                    // first half: opcode and ma[5:0], no data lines touched
                    memory_cmd_addr_bus_out <= {ma_r[5:0],
                        is_mrr_r ? `CA_OP_MRR : `CA_OP_MRW};
                    mem_cs_n_out <= 1'b0;
                    state_r <= S_LO;
                end
            end
            S_LO: begin
                if (link_fall) begin
                    memory_cmd_addr_bus_out <= {op_r, ma_r[7:6]};
                    cnt_r <= 5'h00;
                    state_r <= S_WAIT;
                end
            end
            S_WAIT: begin
                if (link_rise) begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        mem_cs_n_out <= 1'b1;
                        memory_cmd_addr_bus_out <= 10'h000;
                    end
                    // only the first beat of the burst of eight matters
                    if (is_mrr_r && (cnt_r == {1'b0, rl_now})) begin
                        rbyte_r <= dq_s;
                    end
                    if (cnt_r == wait_tgt - 5'h01) begin
                        if (is_mrr_r) begin
                            read_data_valid_out <= 1'b1;
                            read_data_out <= {{4*DATA_WIDTH-8{1'b0}}, rbyte_r};
                            state_r <= S_RESP;
                        end else begin
                            // shadow fields follow what the memory now holds
                            case (ma_r)
                                `MR_BURST: begin
                                    bl_r <= op_r[2:0];
                                    wr_r <= op_r[7:5];
                                end
                                `MR_LAT: begin
                                    rlwl_r <= op_r[3:0];
                                    nwre_r <= op_r[4];
                                    wlsel_r <= op_r[6];
                                    wlev_r <= op_r[7];
                                end
                                `MR_DRIVE: ds_r <= op_r[3:0];
                                `MR_TERM: begin
                                    odt_r <= op_r[1:0];
                                    pd_r <= op_r[2];
                                end
                                default: ds_r <= ds_r;
                            endcase
                            if (from_init_r && (init_idx_r != `INIT_LAST)) begin
                                init_idx_r <= init_idx_r + 2'h1;
                                state_r <= S_INIT;
                            end else begin
                                init_done_out <= 1'b1;
                                state_r <= S_IDLE;
                            end
                        end
                    end
                end
            end
            S_RESP: begin
                // second valid cycle carries no register data; 1f marks it
                read_data_out <= {4*DATA_WIDTH{1'b0}};
                read_data_valid_out <= (cnt_r != 5'h1f);
                cnt_r <= 5'h1f;
                if (cnt_r == 5'h1f) begin
                    state_r <= S_IDLE;
                end
            end
            default: state_r <= S_IDLE;
        endcase
    end
end

// ----------------------------------------
// configuration outputs
// ----------------------------------------
always @(posedge mclk_in) begin
    if (sys_rst_in) begin
        read_latency_out <= 4'h6;
        write_latency_out <= 4'h3;
        burst_length_code_out <= 3'h0;
        write_request_to_data_delay_out <= WDLY_INIT;
        refresh_burst_count_out <= burst_count(RSEL_INIT);
    end else begin
        read_latency_out <= rl_now;
        write_latency_out <= (rlwl_r == `RLWL_RL3) ? 4'h1 :
            (rlwl_r == `RLWL_RL8) ? 4'h4 : 4'h3;
        burst_length_code_out <= bl_r;
        write_request_to_data_delay_out <= wdly_r;
        refresh_burst_count_out <= burst_count(rsel_r);
    end
end

// ----------------------------------------
// avalon-mm slave, one wait state per access
// ----------------------------------------
assign bus_req = avs_read_in || avs_write_in;

always @(posedge mclk_in) begin
    if (sys_rst_in) begin
        avs_waitrequest_out <= 1'b1;
        avs_readdata_out <= 32'h00000000;
        cmd_en_r <= `CTRL_EN_RST;
        wdly_r <= WDLY_INIT;
        rsel_r <= RSEL_INIT;
    end else begin
        if (bus_req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            case (avs_address_in)
                `REG_CTRL: avs_readdata_out <= {21'h000000, rsel_r, 2'h0, wdly_r,
                    3'h0, cmd_en_r};
                `REG_STATUS: avs_readdata_out <= {20'h00000, write_latency_out,
                    read_latency_out, 2'h0, (state_r != S_IDLE), init_done_out};
                `REG_CONFIG: avs_readdata_out <= {12'h000, pd_r, odt_r, ds_r, wlev_r,
                    wlsel_r, nwre_r, rlwl_r, wr_r, bl_r};
                default: avs_readdata_out <= 32'h00000000;
            endcase
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
        if (avs_write_in && !avs_waitrequest_out && avs_address_in == `REG_CTRL) begin
            cmd_en_r <= avs_writedata_in[`CTRL_EN_BIT];
            // zero is not a legal delay, it keeps the old value
            if (avs_writedata_in[`CTRL_WDLY_HI:`CTRL_WDLY_LO] != 2'h0) begin
                wdly_r <= avs_writedata_in[`CTRL_WDLY_HI:`CTRL_WDLY_LO];
            end
            rsel_r <= avs_writedata_in[`CTRL_RSEL_HI:`CTRL_RSEL_LO];
        end
    end
end

endmodule // mode_reg_access

// ===== mra_map.vh
// constants for the mode register access block
`ifndef MRA_MAP_VH
`define MRA_MAP_VH

// ----------------------------------------
// avalon register byte offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CONFIG 4'h8

// ----------------------------------------
// control register fields and reset values
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_WDLY_LO 4
`define CTRL_WDLY_HI 5
`define CTRL_RSEL_LO 8
`define CTRL_RSEL_HI 10
`define CTRL_EN_RST 1'b1
`define WDLY_RST 2'h1
`define RSEL_RST 3'h2

// ----------------------------------------
// user command codes
// ----------------------------------------
`define CMD_MRW 4'h8
`define CMD_MRR 4'h9

// ----------------------------------------
// command/address bus opcodes (ca[3:0])
// ----------------------------------------
`define CA_OP_MRW 4'h0
`define CA_OP_MRR 4'h8

// ----------------------------------------
// mode register numbers used at init
// ----------------------------------------
`define MR_BURST 8'h01
`define MR_LAT 8'h02
`define MR_DRIVE 8'h03
`define MR_TERM 8'h0b
`define INIT_LAST 2'h3

// ----------------------------------------
// initial mode register field values
// ----------------------------------------
`define INIT_BL 3'h3
`define INIT_WR 3'h4
`define RLWL_RL3 4'h1
`define RLWL_RL6 4'h4
`define RLWL_RL8 4'h6
`define INIT_DS 4'h2
`define INIT_ODT 2'h0

// ----------------------------------------
// timing in memory clock cycles, link clock period in ns
// ----------------------------------------
`define T_MRW 5'd10
`define T_MRR 5'd4
`define LINK_PERIOD_NS 800

`endif

// ===== sync2.v
// two flip-flop synchroniser for inputs from another clock domain
`timescale 1ns/1ps
module sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire mclk_in,
    input wire sys_rst_in,
    // asynchronous level in, synchronised level out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;

always @(posedge mclk_in) begin
    if (sys_rst_in) begin
        meta_r <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end

endmodule // sync2

// ===== lpddr_mr_model.sv
// memory device model answering mode register traffic on the link
`timescale 1ns/1ps
module lpddr_mr_model (
    // link side
    input wire mem_clk_in,
    input wire mem_cs_n_in,
    input wire [9:0] ca_in,
    output reg [31:0] dq_out
);
    // ----------------------------------------
    // mode register store and read return
    // ----------------------------------------
    reg [7:0] mr_mem [0:255];
    reg [9:0] half_r = 10'h000;
    reg rd_r = 1'b0;
    reg [7:0] rd_ma_r = 8'h00;
    reg [3:0] n_r = 4'h0;
    reg [3:0] rl_r = 4'h6;
    initial dq_out = 32'h0;
    // first half of a command is on the bus at the falling edge
    always @(negedge mem_clk_in) begin
        if (!mem_cs_n_in) half_r <= ca_in;
    end
    always @(posedge mem_clk_in) begin
        if (!mem_cs_n_in && half_r[3:0] == 4'h0) begin
            mr_mem[{ca_in[1:0], half_r[9:4]}] <= ca_in[9:2];
            if ({ca_in[1:0], half_r[9:4]} == 8'h02) begin
                rl_r <= (ca_in[5:2] == 4'h1) ? 4'd3 : (ca_in[5:2] == 4'h6) ? 4'd8 : 4'd6;
            end
        end else if (!mem_cs_n_in) begin
            rd_ma_r <= {ca_in[1:0], half_r[9:4]};
            n_r <= 4'h0;
            rd_r <= 1'b1;
        end else if (rd_r) begin
            n_r <= n_r + 4'h1;
        end
        // data held two link cycles around read latency, else toggling garbage
        if (rd_r && n_r + 4'd2 == rl_r) dq_out <= {~dq_out[31:8], mr_mem[rd_ma_r]};
        else if (!(rd_r && n_r + 4'd1 == rl_r)) dq_out <= ~dq_out;
        if (rd_r && n_r + 4'd1 == rl_r) rd_r <= 1'b0;
    end
endmodule // lpddr_mr_model

// ===== mra_assertions.sv
// concurrent checks on the ports of the mode register access block
`timescale 1ns/1ps
`include "mra_map.vh"
module mra_assertions #(
    parameter DATA_WIDTH = 32
) (
    // watched ports
    input wire mclk_in,
    input wire sys_rst_in,
    input wire cmd_valid_in,
    input wire [3:0] cmd_in,
    input wire cmd_rdy_out,
    input wire init_done_out,
    input wire read_data_valid_out,
    input wire [4*DATA_WIDTH-1:0] read_data_out,
    input wire [1:0] write_request_to_data_delay_out,
    input wire [3:0] read_latency_out,
    input wire [3:0] write_latency_out,
    input wire [2:0] burst_length_code_out,
    input wire [9:0] memory_cmd_addr_bus_out,
    input wire mem_cs_n_out,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire avs_waitrequest_out
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // cycles since last command start, saturating so long idles never wrap
    reg [7:0] gap_r;
    always @(posedge mclk_in) begin
        if (sys_rst_in) gap_r <= 8'hff;
        else if ($fell(mem_cs_n_out)) gap_r <= 8'h00;
        else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
    end
    property p_ca_idle; mem_cs_n_out |-> memory_cmd_addr_bus_out == 10'h000; endproperty
    a_ca_idle: assert property (p_ca_idle) else $error("ca not idle");
    property p_ca_op; $fell(mem_cs_n_out) |-> memory_cmd_addr_bus_out[3:0] == `CA_OP_MRW
        || memory_cmd_addr_bus_out[3:0] == `CA_OP_MRR; endproperty
    a_ca_op: assert property (p_ca_op) else $error("bad ca opcode");
    property p_gap; $fell(mem_cs_n_out) |-> gap_r >= 8'd48; endproperty
    a_gap: assert property (p_gap) else $error("commands too close");
    property p_rdy_drop; cmd_valid_in && cmd_rdy_out && (cmd_in == `CMD_MRW
        || cmd_in == `CMD_MRR) |=> !cmd_rdy_out [*8]; endproperty
    a_rdy_drop: assert property (p_rdy_drop) else $error("ready after accept");
    property p_no_rdy_init; !init_done_out |-> !cmd_rdy_out; endproperty
    a_no_rdy_init: assert property (p_no_rdy_init) else $error("ready in init");
    property p_init_cfg; $rose(init_done_out) |-> burst_length_code_out == `INIT_BL
        && read_latency_out == 4'd6; endproperty
    a_init_cfg: assert property (p_init_cfg) else $error("init config wrong");
    property p_wait_one; (avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
    property p_valid_two; $rose(read_data_valid_out) |=> read_data_valid_out
        ##1 !read_data_valid_out; endproperty
    a_valid_two: assert property (p_valid_two) else $error("valid not two");
    property p_second_zero; read_data_valid_out && $past(read_data_valid_out)
        |-> read_data_out == '0; endproperty
    a_second_zero: assert property (p_second_zero) else $error("second beat");
    property p_lat_pair; (read_latency_out == 4'd6 && write_latency_out == 4'd3)
        || (read_latency_out == 4'd8 && write_latency_out == 4'd4)
        || (read_latency_out == 4'd3 && write_latency_out == 4'd1); endproperty
    a_lat_pair: assert property (p_lat_pair) else $error("latency pair");
    property p_wdly; write_request_to_data_delay_out != 2'h0; endproperty
    a_wdly: assert property (p_wdly) else $error("write delay zero");
    c_mrr: cover property ($rose(read_data_valid_out));
    c_cmd: cover property ($fell(mem_cs_n_out));
    c_avs: cover property (avs_write_in && !avs_waitrequest_out);
endmodule // mra_assertions
bind mode_reg_access mra_assertions #(.DATA_WIDTH(DATA_WIDTH)) chk (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_rdy_out(cmd_rdy_out), .init_done_out(init_done_out),
    .read_data_valid_out(read_data_valid_out), .read_data_out(read_data_out),
    .write_request_to_data_delay_out(write_request_to_data_delay_out),
    .read_latency_out(read_latency_out), .write_latency_out(write_latency_out),
    .burst_length_code_out(burst_length_code_out),
    .memory_cmd_addr_bus_out(memory_cmd_addr_bus_out), .mem_cs_n_out(mem_cs_n_out),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out));

// ===== tb_top.sv
// self-checking bench for the mode register access block
`timescale 1ns/1ps
`include "mra_map.vh"
module tb_top;
    // ----------------------------------------
    // signals, tasks and sequence
    // ----------------------------------------
    reg mclk_in;
    reg mem_clk_in;
    reg sys_rst_in;
    reg cmd_valid_in;
    reg [3:0] cmd_in;
    reg [27:0] addr_in;
    reg [3:0] avs_address_in;
    reg avs_read_in;
    reg avs_write_in;
    reg [31:0] avs_writedata_in;
    wire cmd_rdy_out;
    wire init_done_out;
    wire read_data_valid_out;
    wire [127:0] read_data_out;
    wire [1:0] wdly_out;
    wire [13:0] refresh_out;
    wire [3:0] rl_out;
    wire [3:0] wl_out;
    wire [2:0] bl_out;
    wire [9:0] ca_bus;
    wire cs_n;
    wire [31:0] dq;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out;
    integer failures;
    integer comparisons;
    integer i;
    integer k;
    reg [7:0] q_mrr [$];
    reg [31:0] q_avs [$];
    reg vprev;
    reg [31:0] r32;
    reg [31:0] up_r;
    reg [7:0] ff_val;
    reg [7:0] ma;
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // link clock with an unrelated phase
    initial begin
        mem_clk_in = 1'b0;
        #37;
        forever #400 mem_clk_in = ~mem_clk_in;
    end
    mode_reg_access uut (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .addr_in(addr_in), .cmd_rdy_out(cmd_rdy_out),
        .init_done_out(init_done_out), .read_data_valid_out(read_data_valid_out),
        .read_data_out(read_data_out), .write_request_to_data_delay_out(wdly_out),
        .refresh_burst_count_out(refresh_out), .read_latency_out(rl_out),
        .write_latency_out(wl_out), .burst_length_code_out(bl_out), .mem_clk_in(mem_clk_in),
        .mem_dq_in(dq), .memory_cmd_addr_bus_out(ca_bus), .mem_cs_n_out(cs_n),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));
    lpddr_mr_model mem (.mem_clk_in(mem_clk_in), .mem_cs_n_in(cs_n), .ca_in(ca_bus),
        .dq_out(dq));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons=%0d failures=%0d", comparisons, failures);
            if (failures == 0 && comparisons > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // every wait is bounded; running out ends the run as a failure
    task step;
        begin
            @(posedge mclk_in);
            k = k + 1;
            if (k > 4000) begin
                failures = failures + 1;
                tally_and_finish;
            end
        end
    endtask
    task issue(input [3:0] c, input [7:0] op, input [7:0] m);
        begin
            up_r = $urandom;
            @(posedge mclk_in);
            cmd_valid_in <= 1'b1;
            cmd_in <= c;
            addr_in <= {up_r[11:0], op, m};
            k = 0;
            step;
            while (cmd_rdy_out !== 1'b1) step;
            cmd_valid_in <= 1'b0;
            step;
            while (cmd_rdy_out !== 1'b1) step;
        end
    endtask
    task mrr(input [7:0] m, input [7:0] ex);
        begin
            q_mrr.push_back(ex);
            issue(`CMD_MRR, 8'ha5, m);
            k = 0;
            while (q_mrr.size() != 0) step;
        end
    endtask
    task avs(input rd, input [3:0] ad, input [31:0] wd, input [31:0] ex);
        begin
            if (rd) q_avs.push_back(ex);
            @(posedge mclk_in);
            avs_read_in <= rd;
            avs_write_in <= !rd;
            avs_address_in <= ad;
            avs_writedata_in <= wd;
            k = 0;
            step;
            while (avs_waitrequest_out !== 1'b0) step;
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask
    always @(posedge mclk_in) begin
        if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
            check(avs_readdata_out, q_avs.pop_front());
        end
        if (read_data_valid_out === 1'b1 && vprev !== 1'b1) begin
            check({24'h0, read_data_out[7:0]}, {24'h0, q_mrr.pop_front()});
            check({31'h0, |read_data_out[127:8]}, 32'h0);
        end
        vprev = read_data_valid_out;
    end
    initial begin
        failures = 0;
        comparisons = 0;
        vprev = 1'b0;
        sys_rst_in = 1'b1;
        cmd_valid_in = 1'b0;
        cmd_in = 4'h0;
        addr_in = 28'h0;
        avs_address_in = 4'h0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        r32 = $urandom(32'hea4b2100);
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        check({30'h0, wdly_out}, 32'h1);
        check({18'h0, refresh_out}, 32'd32);
        check({24'h0, wl_out, rl_out}, 32'h36);
        k = 0;
        while (init_done_out !== 1'b1) step;
        check({29'h0, bl_out}, {29'h0, `INIT_BL});
        avs(1'b1, `REG_STATUS, 32'h0, 32'h0000_0361);
        avs(1'b1, `REG_CONFIG, 32'h0, 32'h0000_4123);
        avs(1'b1, 4'hc, 32'h0, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            avs(1'b0, `REG_CTRL, (i << 8) | ((i % 3 + 1) << 4) | 1, 32'h0);
            repeat (2) @(posedge mclk_in);
            check({18'h0, refresh_out}, (i < 3) ? (1 << (i * 3 - (i == 2))) : (512 << (i - 3)));
            check({30'h0, wdly_out}, i % 3 + 1);
        end
        avs(1'b0, `REG_CTRL, 32'h0000_0201, 32'h0);
        avs(1'b1, `REG_CTRL, 32'h0, 32'h0000_0221);
        // disabled commands must never be accepted
        avs(1'b0, `REG_CTRL, 32'h0000_0220, 32'h0);
        @(posedge mclk_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= `CMD_MRR;
        k = 0;
        repeat (16) begin
            @(posedge mclk_in);
            if (cmd_rdy_out !== 1'b0) k = k + 1;
        end
        cmd_valid_in <= 1'b0;
        check(k, 0);
        avs(1'b0, `REG_CTRL, 32'h0000_0221, 32'h0);
        mrr(`MR_BURST, 8'h83);
        mrr(`MR_LAT, 8'h04);
        mrr(`MR_DRIVE, 8'h02);
        mrr(`MR_TERM, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            r32 = $urandom;
            ma = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : {1'b1, r32[14:8]};
            issue(`CMD_MRW, r32[7:0], ma);
            mrr(ma, r32[7:0]);
            if (ma == 8'hff) ff_val = r32[7:0];
        end
        for (i = 0; i < 3; i = i + 1) begin
            r32 = (i == 0) ? 32'h0004_0806 : (i == 1) ? 32'h0001_0301 : 32'h0003_0604;
            issue(`CMD_MRW, r32[7:0], `MR_LAT);
            check({28'h0, rl_out}, r32[15:8]);
            check({28'h0, wl_out}, r32[19:16]);
            mrr(8'hff, ff_val);
        end
        tally_and_finish;
    end
endmodule // tb_top
